// ===== rtl/spd_defines.vh
`ifndef SPD_DEFINES_VH
`define SPD_DEFINES_VH
// ****************************************
// Register map
// ****************************************
`define SPD_ADDR_CTRL     4'h0
`define SPD_ADDR_STAT     4'h1
`define SPD_ADDR_CNTR     4'h2
`define SPD_ADDR_RXDATA   4'h3
`define SPD_ADDR_TXDATA   4'h4
`define SPD_ADDR_PC       4'h5
// ****************************************
// Control fields
// ****************************************
`define SPD_CTRL_DBG      0
`define SPD_CTRL_BRKEN    1
`define SPD_CTRL_LOOP     2
`define SPD_CTRL_PCMATCH  3
`define SPD_CTRL_CNTDN    4
`define SPD_CTRL_CYCCNT   5
`define SPD_CTRL_RESET    8'h00
// ****************************************
// Link timing
// ****************************************
`define SPD_SYNC_LOWBITS  4'h8
`define SPD_BREAK_BITS    4'h9
`define SPD_TXBRK_CYCLES  13'h1000
`define SPD_BRK_OPCODE    8'h00
`define SPD_CNT_MAX       16'hffff
`define SPD_MIN_BIT       16'h0004
`define SPD_MAX_BIT       16'h0200
`define SPD_STRAP_EDGE    2'h2
`define SPD_STRAP_DONE    2'h3
`endif

// ===== rtl/spd_debug_link.v
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`include "spd_defines.vh"
module spd_debug_link #(
    parameter TXBRK_CYCLES = 4096
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        debug_pin_in,
    output wire        debug_pin_out,
    output wire        debug_pin_oe,
    input  wire        stop_mode,
    input  wire        cpu_brk_decode,
    input  wire        cpu_brk_return,
    input  wire [15:0] cpu_pc,
    output wire        cpu_fetch_stop,
    output wire        cpu_brk_loop,
    output reg         sys_reset_req,
    output wire        debug_mode,
    output wire        cmd_enable,
    output reg         rx_valid,
    output reg  [7:0]  rx_data
);
// ****************************************
// Pin synchroniser
// ****************************************
reg        pin_s1;
reg        pin_s2;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pin_s1 <= 1'b1;
        pin_s2 <= 1'b1;
    end else begin
        pin_s1 <= debug_pin_in;
        pin_s2 <= pin_s1;
    end
end
// ****************************************
// Bus slave
// ****************************************
reg        wr_pend;
reg  [3:0] wr_idx;
wire       req_go  = hsel & hready & htrans[1];
wire [3:0] req_idx = haddr[5:2];
assign hreadyout = 1'b1;
assign hresp     = 1'b0;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend <= 1'b0;
        wr_idx  <= 4'h0;
    end else begin
        wr_pend <= req_go & hwrite;
        wr_idx  <= req_idx;
    end
end
wire wr_ctrl = wr_pend && (wr_idx == `SPD_ADDR_CTRL);
wire wr_cntr = wr_pend && (wr_idx == `SPD_ADDR_CNTR);
wire wr_tx   = wr_pend && (wr_idx == `SPD_ADDR_TXDATA);
wire rd_rx   = req_go && !hwrite && (req_idx == `SPD_ADDR_RXDATA);
// ****************************************
// Control and mode
// ****************************************
reg  [7:0]  ctrl;
reg  [15:0] cntr;
reg  [1:0]  strap_cnt;
reg         looping;
wire        brk_en  = ctrl[`SPD_CTRL_BRKEN];
wire        loop_en = ctrl[`SPD_CTRL_LOOP];
wire        dbg     = ctrl[`SPD_CTRL_DBG];
wire        pc_hit  = ctrl[`SPD_CTRL_PCMATCH] && (cpu_pc == cntr);
wire        cd_hit  = ctrl[`SPD_CTRL_CNTDN] && (cntr == 16'h0000);
wire        brk_hit = cpu_brk_decode && brk_en && !loop_en;
wire        lp_back = looping && !loop_en && cpu_brk_return;
wire        enter   = brk_hit | lp_back | (!dbg && (pc_hit | cd_hit));
assign debug_mode     = dbg;
assign cpu_fetch_stop = dbg;
assign cpu_brk_loop   = looping;
assign cmd_enable     = dbg && !looping;
// Hardware reset of hresetn covers power-on, brownout and reset pin
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl       <= `SPD_CTRL_RESET;
        strap_cnt  <= 2'h0;
        looping    <= 1'b0;
    end else begin
        // Synchroniser needs two edges before the pin level is valid
        if (strap_cnt != `SPD_STRAP_DONE)
            strap_cnt <= strap_cnt + 2'h1;
        if (wr_ctrl)
            ctrl <= hwdata[7:0];
        if (strap_cnt == `SPD_STRAP_EDGE && !pin_s2)
            ctrl[`SPD_CTRL_DBG] <= 1'b1;
        if (enter)
            ctrl[`SPD_CTRL_DBG] <= 1'b1;
        if (cpu_brk_decode && brk_en && loop_en)
            looping <= 1'b1;
        else if (lp_back || dbg)
            looping <= 1'b0;
    end
end
// Stop-mode wake by pin low
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
        sys_reset_req <= 1'b0;
    else
        sys_reset_req <= stop_mode && !pin_s2;
end
// ****************************************
// Counter
// ****************************************
reg dbg_q;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cntr  <= 16'h0000;
        dbg_q <= 1'b0;
    end else begin
        dbg_q <= dbg;
        if (wr_cntr)
            cntr <= hwdata[15:0];
        else if (ctrl[`SPD_CTRL_CYCCNT]) begin
            if (dbg_q && !dbg)
                cntr <= 16'h0000;
            else if (!dbg && cntr != `SPD_CNT_MAX)
                cntr <= cntr + 16'h0001;
        end else if (ctrl[`SPD_CTRL_CNTDN] && !dbg && cntr != 16'h0000)
            cntr <= cntr - 16'h0001;
    end
end
// ****************************************
// Serial link
// ****************************************
localparam ST_IDLE  = 3'h0;
localparam ST_SYNC  = 3'h1;
localparam ST_READY = 3'h2;
localparam ST_RX    = 3'h3;
localparam ST_TX    = 3'h4;
localparam ST_TXBRK = 3'h5;
localparam ST_HOLD  = 3'h6;
localparam [19:0] TXBRK_LAST = TXBRK_CYCLES - 1;
reg  [2:0]  state;
reg  [15:0] bit_len;
reg  [19:0] tcnt;
reg  [3:0]  bitn;
reg  [8:0]  shreg;
reg         drv_low;
reg         fr_err;
reg         coll;
reg         brk_seen;
reg  [7:0]  tx_buf;
reg         tx_full;
wire [19:0] bit_w  = {4'h0, bit_len};
wire [19:0] half_w = {5'h00, bit_len[15:1]};
wire [19:0] brk_w  = bit_w * {16'h0000, `SPD_BREAK_BITS};
assign debug_pin_out = 1'b0;
assign debug_pin_oe  = drv_low;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state    <= ST_IDLE;
        bit_len  <= 16'h0000;
        tcnt     <= 20'h00000;
        bitn     <= 4'h0;
        shreg    <= 9'h000;
        drv_low  <= 1'b0;
        fr_err   <= 1'b0;
        coll     <= 1'b0;
        brk_seen <= 1'b0;
        rx_valid <= 1'b0;
        rx_data  <= 8'h00;
        tx_buf   <= 8'h00;
        tx_full  <= 1'b0;
    end else begin
        if (wr_tx && !tx_full) begin
            tx_buf  <= hwdata[7:0];
            tx_full <= 1'b1;
        end
        if (rd_rx)
            rx_valid <= 1'b0;
        case (state)
            ST_IDLE: begin
                tcnt <= 20'h00000;
                if (!pin_s2) begin
                    // Detecting edge counts as the first low cycle
                    tcnt  <= 20'h00001;
                    state <= ST_SYNC;
                end
            end
            ST_SYNC: begin
                if (pin_s2) begin
                    // Eight low bit times of the sync character
                    bit_len <= tcnt[18:3];
                    if (tcnt[18:3] < `SPD_MIN_BIT || tcnt[18:3] > `SPD_MAX_BIT)
                        state <= ST_IDLE;
                    else
                        state <= ST_READY;
                end else
                    tcnt <= tcnt + 20'h00001;
            end
            ST_READY: begin
                tcnt <= 20'h00000;
                bitn <= 4'h0;
                if (!pin_s2) begin
                    tcnt  <= 20'h00001;
                    state <= ST_RX;
                end else if (tx_full) begin
                    shreg   <= {tx_buf, 1'b0};
                    tx_full <= 1'b0;
                    drv_low <= 1'b1;
                    state   <= ST_TX;
                end
            end
            ST_RX: begin
                tcnt <= tcnt + 20'h00001;
                if (pin_s2)
                    tcnt <= tcnt + 20'h00001;
                if (!pin_s2 && tcnt >= brk_w) begin
                    brk_seen <= 1'b1;
                    tcnt     <= 20'h00000;
                    drv_low  <= 1'b1;
                    state    <= ST_TXBRK;
                end else if (tcnt == half_w + bit_w * {16'h0000, bitn}) begin
                    // Mid-bit sampling
                    if (bitn == 4'h9) begin
                        if (!pin_s2) begin
                            if (shreg[8:1] != 8'h00) begin
                                fr_err  <= 1'b1;
                                tcnt    <= 20'h00000;
                                drv_low <= 1'b1;
                                state   <= ST_TXBRK;
                            end
                        end else begin
                            rx_data  <= shreg[8:1];
                            rx_valid <= 1'b1;
                            state    <= ST_READY;
                        end
                    end else begin
                        shreg <= {pin_s2, shreg[8:1]};
                        bitn  <= bitn + 4'h1;
                    end
                end
            end
            ST_TX: begin
                tcnt <= tcnt + 20'h00001;
                if (tcnt == bit_w - 20'h00001) begin
                    tcnt <= 20'h00000;
                    bitn <= bitn + 4'h1;
                    if (bitn == 4'h9) begin
                        drv_low <= 1'b0;
                        state   <= ST_READY;
                    end else begin
                        drv_low <= (bitn == 4'h8) ? 1'b0 : !shreg[1];
                        shreg   <= {1'b1, shreg[8:1]};
                    end
                end else if (!drv_low && !pin_s2 && tcnt > {18'h00000, 2'h3}) begin
                    coll    <= 1'b1;
                    tcnt    <= 20'h00000;
                    drv_low <= 1'b1;
                    state   <= ST_TXBRK;
                end
            end
            ST_TXBRK: begin
                // Command aborted, pending byte dropped
                tx_full <= 1'b0;
                tcnt    <= tcnt + 20'h00001;
                if (tcnt == TXBRK_LAST) begin
                    drv_low <= 1'b0;
                    state   <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Held until the line floats high again
                tcnt <= 20'h00000;
                if (pin_s2) begin
                    bit_len  <= 16'h0000;
                    fr_err   <= 1'b0;
                    coll     <= 1'b0;
                    brk_seen <= 1'b0;
                    state    <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end
// ****************************************
// Read mux
// ****************************************
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
        hrdata <= 32'h00000000;
    else if (req_go && !hwrite) begin
        case (req_idx)
            `SPD_ADDR_CTRL:   hrdata <= {24'h000000, ctrl};
            `SPD_ADDR_STAT:   hrdata <= {16'h0000, bit_len[7:0], tx_full, rx_valid,
                                         brk_seen, coll, fr_err, looping,
                                         (state == ST_READY), dbg};
            `SPD_ADDR_CNTR:   hrdata <= {16'h0000, cntr};
            `SPD_ADDR_RXDATA: hrdata <= {24'h000000, rx_data};
            `SPD_ADDR_PC:     hrdata <= {16'h0000, cpu_pc};
            default:          hrdata <= 32'h00000000;
        endcase
    end
end
endmodule // spd_debug_link

// ===== verif/spd_checker.sv
module spd_checker #(
    parameter TXBRK_CYCLES = 4096
) (
    input wire       hclk,
    input wire       hresetn,
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hwrite,
    input wire       debug_pin_in,
    input wire       debug_pin_out,
    input wire       debug_pin_oe,
    input wire       stop_mode,
    input wire       cpu_fetch_stop,
    input wire       cpu_brk_loop,
    input wire       sys_reset_req,
    input wire       debug_mode,
    input wire       cmd_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Mode and link checks
    // ****
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    int oe_run;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            oe_run <= 0;
        else
            oe_run <= debug_pin_oe ? oe_run + 1 : 0;
    end
    a_fetch_stop: assert property (cpu_fetch_stop == debug_mode)
        else $error("fetch stop differs from mode");
    a_cmd_gate: assert property (cmd_enable == (debug_mode && !cpu_brk_loop))
        else $error("command enable wrong");
    a_stop_reset: assert property (
        (stop_mode && !debug_pin_in) [*5] |-> sys_reset_req)
        else $error("no reset request in stop");
    a_pin_low: assert property (debug_pin_out == 1'b0)
        else $error("pin driven high");
    a_mode_exit: assert property (
        $fell(debug_mode) |-> $past(hsel && htrans[1] && hwrite, 2))
        else $error("mode left without write");
    a_break_len: assert property (
        $fell(debug_pin_oe) && oe_run > 16 |-> oe_run == TXBRK_CYCLES)
        else $error("break length wrong");
    a_strap_entry: assert property (
        $rose(hresetn) ##0 !debug_pin_in [*4] |-> ##[0:3] debug_mode)
        else $error("strap did not enter debug");
    a_loop_start: assert property ($rose(cpu_brk_loop) |-> !debug_mode)
        else $error("loop started in debug");
endmodule // spd_checker

bind spd_debug_link spd_checker #(.TXBRK_CYCLES(TXBRK_CYCLES)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .debug_pin_in(debug_pin_in), .debug_pin_out(debug_pin_out),
    .debug_pin_oe(debug_pin_oe), .stop_mode(stop_mode), .cpu_fetch_stop(cpu_fetch_stop),
    .cpu_brk_loop(cpu_brk_loop), .sys_reset_req(sys_reset_req), .debug_mode(debug_mode),
    .cmd_enable(cmd_enable)
);

// ===== verif/spd_host_model.sv
module spd_host_model (
    input  wire  hclk,
    input  wire  dut_oe,
    output logic host_oe,
    output wire  pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Host end of the line
    // ****
    initial host_oe = 1'b0;
    assign pin = !(host_oe || dut_oe);
    task automatic send_byte(input int bl, input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_oe <= !f[i];
            repeat (bl) @(posedge hclk);
        end
        host_oe <= 1'b0;
    endtask
    task automatic recv_byte(input int bl, output logic [7:0] d);
        while (pin !== 1'b0) @(posedge hclk);
        repeat (bl / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            repeat (bl) @(posedge hclk);
            d[i] = pin;
        end
    endtask
    task automatic send_break(input int n);
        host_oe <= 1'b1;
        repeat (n) @(posedge hclk);
        host_oe <= 1'b0;
    endtask
endmodule // spd_host_model

// ===== verif/test_single_pin_debug_link.sv
module test_single_pin_debug_link;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Bench
    // ****
    localparam int BREAKPOINT_INSTRUCTION = 64;
    localparam int BL = 8;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        stop_mode = 1'b0;
    logic        brk_dec = 1'b0;
    logic        brk_ret = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [15:0] pc = 16'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] seed = 32'hb9d28e4d;
    logic [31:0] t_addr;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cyc = 0;
    wire  [31:0] hrdata;
    wire  [7:0]  rxd;
    wire         hrdy, pin, pin_oe, host_oe, dbg, rst_req, rxv;
    always #5 hclk = ~hclk;
    spd_debug_link #(.TXBRK_CYCLES(BREAKPOINT_INSTRUCTION)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
        .hresp(), .hrdata(hrdata), .debug_pin_in(pin), .debug_pin_out(), .debug_pin_oe(pin_oe),
        .stop_mode(stop_mode), .cpu_brk_decode(brk_dec), .cpu_brk_return(brk_ret),
        .cpu_pc(pc), .cpu_fetch_stop(), .cpu_brk_loop(), .sys_reset_req(rst_req),
        .debug_mode(dbg), .cmd_enable(), .rx_valid(rxv), .rx_data(rxd)
    );
    spd_host_model i_host (.hclk(hclk), .dut_oe(pin_oe), .host_oe(host_oe), .pin(pin));
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hrdy !== 1'b1);
        t_addr = cyc;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, e, m);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        chk(nm, e & m, rd & m);
    endtask
    task automatic brk_len(output int n);
        n = 0;
        while (pin_oe !== 1'b1) @(negedge hclk);
        while (pin_oe === 1'b1) begin
            @(negedge hclk);
            n++;
        end
    endtask
    initial begin
        logic [31:0] q[$];
        logic [31:0] d, r1, r2, t1;
        logic [5:0]  steps[4] = '{6'h00, 6'h12, 6'h26, 6'h1a};
        int n;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("ctrl_rst", 32'h0, 32'h0, 32'h3f);
        rchk("unmapped", 32'h18, 32'h0, 32'hffffffff);
        i_host.send_byte(BL, 8'h80, 1'b1);
        repeat (2 * BL) @(posedge hclk);
        rchk("bit_len", 32'h4, 32'(BL * 256 + 2), 32'hff02);
        bus(1'b0, 32'hc, 32'h0, d);
        repeat (3) begin
            d = rnd() | 32'h80;
            q.push_back(d & 32'hff);
            i_host.send_byte(BL, d[7:0], 1'b1);
            @(negedge hclk);
            chk("rx_port", q[0], {24'h0, rxd});
            chk("rx_vld", 32'h1, {31'h0, rxv});
            rchk("rx_reg", 32'hc, q.pop_front(), 32'hff);
            chk("rx_clr", 32'h0, {31'h0, rxv});
        end
        wr(32'h10, 32'h5a);
        i_host.recv_byte(BL, d[7:0]);
        chk("tx_byte", 32'h5a, d & 32'hff);
        repeat (2 * BL) @(posedge hclk);
        wr(32'h0, 32'h1);
        @(negedge hclk);
        chk("dbg_wr", 32'h1, {31'h0, dbg});
        @(posedge hclk);
        fork
            i_host.send_break(12 * BL);
        join_none
        brk_len(n);
        chk("brk_host", 32'(BREAKPOINT_INSTRUCTION), 32'(n));
        while (pin !== 1'b1) @(negedge hclk);
        chk("brk_mode", 32'h1, {31'h0, dbg});
        rchk("brk_ctrl", 32'h0, 32'h1, 32'h3f);
        rchk("brk_link", 32'h4, 32'h0, 32'h2);
        i_host.send_byte(BL, 8'h80, 1'b1);
        repeat (2 * BL) @(posedge hclk);
        wr(32'h10, 32'h5a);
        repeat (20) @(posedge hclk);
        fork
            i_host.send_break(8);
        join_none
        brk_len(n);
        chk("brk_coll", 32'(BREAKPOINT_INSTRUCTION), 32'(n));
        while (pin !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        i_host.send_byte(BL, 8'h80, 1'b1);
        repeat (2 * BL) @(posedge hclk);
        fork
            i_host.send_byte(BL, 8'h81, 1'b0);
        join_none
        brk_len(n);
        chk("brk_frame", 32'(BREAKPOINT_INSTRUCTION), 32'(n));
        while (pin !== 1'b1) @(negedge hclk);
        foreach (steps[i]) begin
            wr(32'h0, {29'h0, steps[i][2:0]});
            brk_dec <= !steps[i][3];
            brk_ret <= steps[i][3];
            @(posedge hclk);
            brk_dec <= 1'b0;
            brk_ret <= 1'b0;
            repeat (3) @(negedge hclk);
            chk("brk_dbg", {31'h0, steps[i][4]}, {31'h0, dbg});
            rchk("brk_wait", 32'h4, {29'h0, steps[i][5], 2'h0}, 32'h4);
        end
        wr(32'h0, 32'h21);
        wr(32'h0, 32'h20);
        bus(1'b0, 32'h8, 32'h0, r1);
        t1 = t_addr;
        bus(1'b0, 32'h8, 32'h0, r2);
        chk("cnt_delta", t_addr - t1, r2 - r1);
        d = rnd();
        wr(32'h0, 32'h09);
        wr(32'h8, d & 32'hffff);
        @(posedge hclk);
        pc <= ~d[15:0];
        wr(32'h0, 32'h08);
        repeat (4) @(negedge hclk);
        chk("pc_idle", 32'h0, {31'h0, dbg});
        @(posedge hclk);
        pc <= d[15:0];
        repeat (4) @(negedge hclk);
        chk("pc_match", 32'h1, {31'h0, dbg});
        wr(32'h0, 32'h11);
        wr(32'h8, 32'h20);
        wr(32'h0, 32'h10);
        repeat (8) @(negedge hclk);
        chk("cd_idle", 32'h0, {31'h0, dbg});
        repeat (40) @(negedge hclk);
        chk("cd_hit", 32'h1, {31'h0, dbg});
        @(posedge hclk);
        stop_mode <= 1'b1;
        fork
            i_host.send_break(10);
        join_none
        repeat (8) @(negedge hclk);
        chk("stop_rst", 32'h1, {31'h0, rst_req});
        repeat (4) @(posedge hclk);
        stop_mode <= 1'b0;
        hresetn <= 1'b0;
        fork
            i_host.send_break(40);
        join_none
        repeat (2) @(negedge hclk);
        chk("rst_exit", 32'h0, {31'h0, dbg});
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(negedge hclk);
        chk("strap", 32'h1, {31'h0, dbg});
        end_sim();
    end
endmodule // test_single_pin_debug_link
